// ==== hdl/dma_prog_map.svh ====
// offsets, field positions and reset values of the dma programming port
`ifndef DMA_PROG_MAP_SVH
`define DMA_PROG_MAP_SVH

// ==========================================
// i/o port addresses
`define PORT_STAT_LO  16'h0008
`define PORT_MODE_LO  16'h000B
`define PORT_FUNC     16'h0018
`define PORT_EXEC     16'h001A
`define PORT_STAT_HI  16'h00D0
`define PORT_MODE_HI  16'h00D6

// ==========================================
// field positions
`define EM_WORD       6
`define EM_MEMWR      3
`define EM_XFER       2
`define EM_IOADR      0
`define CM_OP_MSB     3
`define CM_OP_LSB     2
`define CM_CH_MSB     1
`define FN_CMD_MSB    7
`define FN_CMD_LSB    4
`define FN_CH_MSB     2

// ==========================================
// reset values and fixed figures
`define MASK_RST      8'hFF
`define ARB0_RST      4'h0
`define ARB4_RST      4'h4
`define ARB_INACTIVE  4'h4
`define FIFO_DEPTH    8
`define FIFO_WIDTH    8

`endif

// ==== hdl/dma_prog_pkg.sv ====
// types of the dma programming port
package dma_prog_pkg;

	// ==========================================
	// extended command codes
	typedef enum logic [3:0] {
		CMD_IOADR  = 4'b0000,
		CMD_MEMWR  = 4'b0010,
		CMD_MEMRD  = 4'b0011,
		CMD_CNTWR  = 4'b0100,
		CMD_CNTRD  = 4'b0101,
		CMD_STAT   = 4'b0110,
		CMD_MODE   = 4'b0111,
		CMD_ARB    = 4'b1000,
		CMD_MSET   = 4'b1001,
		CMD_MCLR   = 4'b1010,
		CMD_MASTER = 4'b1101
	} cmd_t;

	// compatible mode operation field
	typedef enum logic [1:0] {
		OP_VERIFY = 2'b00,
		OP_WRITE  = 2'b01,
		OP_READ   = 2'b10
	} op_t;

	// whole state of the programming port, apart from its answer fifo
	typedef struct packed {
		logic [7:0]        func;
		logic [1:0]        bptr;
		logic [7:0][7:0]   mode;
		logic [7:0][15:0]  ioadr;
		logic [7:0][23:0]  madr;
		logic [7:0][15:0]  cnt;
		logic [7:0]        mask;
		logic [7:0]        term_flag;
		logic [7:0]        req;
		logic [3:0]        arb0;
		logic [3:0]        arb4;
		logic              ch0_act;
		logic              svc_grant;
		logic              svc_word;
		logic              svc_memwr;
		logic              svc_xfer;
		logic [15:0]       svc_ioadr;
	} prog_state_t;

endpackage

// ==== hdl/dma_channel_programming_port.sv ====
// dma channel programming port with its read-answer fifo
`timescale 1ns/1ps
`include "dma_prog_map.svh"

// ==========================================
// read-answer fifo
module answer_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_sys,   // system clock
	input  wire logic             rst_b,     // sync reset, low
	input  wire logic             in_valid,  // push request
	output logic                  in_ready,  // room for a word
	input  wire logic [WIDTH-1:0] in_data,   // pushed word
	output logic                  out_valid, // head word present
	input  wire logic             out_ready, // pop request
	output logic [WIDTH-1:0]      out_data   // head word
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wptr;
		logic [PW-1:0]               rptr;
		logic [CW-1:0]               count;
		logic                        ready;
		logic                        valid;
		logic [WIDTH-1:0]            head;
	} fifo_state_t;

	fifo_state_t q;
	fifo_state_t d;
	logic        do_push;
	logic        do_pop;

	// pointer step with wrap at depth
	function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
		step = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
	endfunction

	// flags and head are registered so every output is a flop
	always_comb begin
		d = q;
		do_push = in_valid && q.ready;
		do_pop  = out_ready && q.valid;
		if (do_push) begin
			d.mem[q.wptr] = in_data;
			d.wptr = step(q.wptr);
		end
		if (do_pop) begin
			d.rptr = step(q.rptr);
		end
		if (do_push && !do_pop) begin
			d.count = CW'(q.count + 1'b1);
		end else if (do_pop && !do_push) begin
			d.count = CW'(q.count - 1'b1);
		end
		d.ready = (d.count != CW'(DEPTH));
		d.valid = (d.count != '0);
		d.head  = d.mem[d.rptr];
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			q <= '0;
			q.ready <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign in_ready  = q.ready;
	assign out_valid = q.valid;
	assign out_data  = q.head;
endmodule // answer_fifo

// ==========================================
// What this block does
// - compat mode bits 3:2 pick verify/write/read
// - compat mode bits 1:0 pick group channel
// - compat mode reformatted, never read back
// - per-channel 8-bit extended mode, read/write
// - extended bit 6 selects byte or word
// - extended bit 3 selects transfer direction
// - extended bit 2 verify versus real transfer
// - extended bit 0 zero or programmed address
// - status bits 3:0 flag terminal count
// - status bits 7:4 flag bus won
// - status clears on reset and read
// - function byte: command high, channel low
// - port 0018 loads, 001A executes function
// - function write resets byte pointer
// - each execute access moves pointer on, holding at 3
// - codes 9, A, D act at once
// - command code meanings, others reserved
// - code 8 writes channel 0/4 level
// - channels other than 0 and 4 answer level zero
// - channel 0 inactive at level 4
// - reset and master clear set masks
module dma_channel_programming_port (
	input  wire logic        clk_sys,       // system clock, 20 MHz
	input  wire logic        rst_b,         // sync reset, low
	input  wire logic [15:0] io_addr,       // i/o port address
	input  wire logic        io_wr,         // i/o write strobe
	input  wire logic        io_rd,         // i/o read strobe
	input  wire logic [7:0]  io_wdata,      // i/o write byte
	output logic             io_rd_ready,   // read may be taken
	output logic             rd_valid,      // answer byte present
	input  wire logic        rd_ready,      // answer byte taken
	output logic [7:0]       rd_data,       // answer byte
	input  wire logic [7:0]  term_event,    // terminal count pulses
	input  wire logic [7:0]  arb_won,       // level won bus pulses
	input  wire logic        svc_req,       // channel asks service
	input  wire logic [2:0]  svc_ch,        // asking channel
	output logic             svc_grant,     // channel may be served
	output logic             svc_word,      // 16-bit transfer
	output logic             svc_memwr,     // memory is written
	output logic             svc_xfer,      // real data transfer
	output logic [15:0]      svc_ioadr,     // i/o address to drive
	output logic [3:0]       arb_level0,    // level of channel 0
	output logic [3:0]       arb_level4,    // level of channel 4
	output logic             ch0_active,    // channel 0 usable
	output logic [7:0]       mask_out       // channel mask bits
);
	import dma_prog_pkg::*;

	prog_state_t q;
	prog_state_t d;
	logic        fifo_ready;
	logic        push;
	logic [7:0]  push_data;
	logic        rd_take;
	logic [2:0]  fch;
	cmd_t        fcmd;
	logic [7:0]  term_clr;
	logic [7:0]  req_clr;
	logic        exec;

	// byte p of a register, low byte first
	function automatic logic [7:0] get_byte(input logic [23:0] v,
	                                        input logic [1:0] p);
		case (p)
			2'b00:   get_byte = v[7:0];
			2'b01:   get_byte = v[15:8];
			2'b10:   get_byte = v[23:16];
			default: get_byte = 8'h00;
		endcase
	endfunction

	// number of bytes behind the pointer for a command
	function automatic logic [1:0] cmd_bytes(input cmd_t c);
		case (c)
			CMD_IOADR: cmd_bytes = 2'd2;
			CMD_MEMWR: cmd_bytes = 2'd3;
			CMD_MEMRD: cmd_bytes = 2'd3;
			CMD_CNTWR: cmd_bytes = 2'd2;
			CMD_CNTRD: cmd_bytes = 2'd2;
			default:   cmd_bytes = 2'd1;
		endcase
	endfunction

	// status byte of the group holding channel c
	function automatic logic [7:0] stat_byte(input logic [7:0] tf,
	                                         input logic [7:0] rq,
	                                         input logic g);
		stat_byte = g ? {rq[7:4], tf[7:4]} : {rq[3:0], tf[3:0]};
	endfunction

	// compat byte reformatted into extended layout
	function automatic logic [7:0] compat_to_ext(input logic [7:0] old,
	                                             input logic [7:0] w);
		compat_to_ext = old;
		case (op_t'(w[`CM_OP_MSB:`CM_OP_LSB]))
			OP_VERIFY: begin
				compat_to_ext[`EM_XFER]  = 1'b0;
				compat_to_ext[`EM_MEMWR] = 1'b0;
			end
			OP_WRITE: begin
				compat_to_ext[`EM_XFER]  = 1'b1;
				compat_to_ext[`EM_MEMWR] = 1'b1;
			end
			OP_READ: begin
				compat_to_ext[`EM_XFER]  = 1'b1;
				compat_to_ext[`EM_MEMWR] = 1'b0;
			end
			default: compat_to_ext = old; // reserved pattern ignored
		endcase
	endfunction

	// ==========================================
	// next state
	always_comb begin
		d = q;
		push = 1'b0;
		push_data = 8'h00;
		term_clr = 8'h00;
		req_clr = 8'h00;
		rd_take = io_rd && fifo_ready;
		fch = q.func[`FN_CH_MSB:0];
		fcmd = cmd_t'(q.func[`FN_CMD_MSB:`FN_CMD_LSB]);
		exec = (io_addr == `PORT_EXEC) && (io_wr || rd_take);

		// function port write and direct commands
		if (io_wr && io_addr == `PORT_FUNC) begin
			d.func = io_wdata;
			d.bptr = 2'b00;
			case (cmd_t'(io_wdata[`FN_CMD_MSB:`FN_CMD_LSB]))
				CMD_MSET:   d.mask[io_wdata[`FN_CH_MSB:0]] = 1'b1;
				CMD_MCLR:   d.mask[io_wdata[`FN_CH_MSB:0]] = 1'b0;
				CMD_MASTER: begin
					d.mask = `MASK_RST;
					term_clr = 8'hFF;
					req_clr = 8'hFF;
				end
				default: ;
			endcase
		end

		// compatible mode ports, write only
		if (io_wr && io_addr == `PORT_MODE_LO) begin
			d.mode[{1'b0, io_wdata[`CM_CH_MSB:0]}] =
				compat_to_ext(q.mode[{1'b0, io_wdata[`CM_CH_MSB:0]}], io_wdata);
		end
		if (io_wr && io_addr == `PORT_MODE_HI) begin
			d.mode[{1'b1, io_wdata[`CM_CH_MSB:0]}] =
				compat_to_ext(q.mode[{1'b1, io_wdata[`CM_CH_MSB:0]}], io_wdata);
		end

		// every taken read yields one answer byte, unmapped reads zero
		if (rd_take) begin
			push = 1'b1;
		end
		if (rd_take && io_addr == `PORT_STAT_LO) begin
			push_data = stat_byte(q.term_flag, q.req, 1'b0);
			term_clr[3:0] = 4'hF;
			req_clr[3:0] = 4'hF;
		end
		if (rd_take && io_addr == `PORT_STAT_HI) begin
			push_data = stat_byte(q.term_flag, q.req, 1'b1);
			term_clr[7:4] = 4'hF;
			req_clr[7:4] = 4'hF;
		end

		// execute port: one byte, then pointer moves unless already at 3
		if (exec) begin
			if (q.bptr != 2'b11) begin
				d.bptr = 2'(q.bptr + 1'b1); // no wrap until next function write
			end
			if (q.bptr < cmd_bytes(fcmd)) begin
				case (fcmd)
					CMD_IOADR: begin
						if (io_wr) begin
							d.ioadr[fch][{q.bptr[0], 3'b000} +: 8] = io_wdata;
						end else begin
							push_data = get_byte({8'h00, q.ioadr[fch]}, q.bptr);
						end
					end
					CMD_MEMWR: begin
						if (io_wr) begin
							d.madr[fch][{q.bptr, 3'b000} +: 8] = io_wdata;
						end
					end
					CMD_MEMRD: begin
						if (!io_wr) begin
							push_data = get_byte(q.madr[fch], q.bptr);
						end
					end
					CMD_CNTWR: begin
						if (io_wr) begin
							d.cnt[fch][{q.bptr[0], 3'b000} +: 8] = io_wdata;
						end
					end
					CMD_CNTRD: begin
						if (!io_wr) begin
							push_data = get_byte({8'h00, q.cnt[fch]}, q.bptr);
						end
					end
					CMD_STAT: begin
						if (!io_wr) begin
							push_data = stat_byte(q.term_flag, q.req, fch[2]);
							term_clr[{fch[2], 2'b00} +: 4] = 4'hF;
							req_clr[{fch[2], 2'b00} +: 4] = 4'hF;
						end
					end
					CMD_MODE: begin
						if (io_wr) begin
							d.mode[fch] = io_wdata;
						end else begin
							push_data = q.mode[fch];
						end
					end
					CMD_ARB: begin
						if (io_wr && fch == 3'd0) begin
							d.arb0 = io_wdata[3:0];
						end
						if (io_wr && fch == 3'd4) begin
							d.arb4 = io_wdata[3:0];
						end
						if (!io_wr && fch == 3'd0) begin
							push_data = {4'h0, q.arb0};
						end
						if (!io_wr && fch == 3'd4) begin
							push_data = {4'h0, q.arb4};
						end
					end
					default: ; // reserved codes do nothing
				endcase
			end
		end

		// events set after clears so a same-cycle event survives
		d.term_flag = (q.term_flag & ~term_clr) | term_event;
		d.req = (q.req & ~req_clr) | arb_won;

		d.ch0_act = (d.arb0 != `ARB_INACTIVE);

		// settings of the requesting channel; masked ones not served
		d.svc_grant = 1'b0;
		if (svc_req) begin
			d.svc_grant = !q.mask[svc_ch] &&
				!(svc_ch == 3'd0 && !q.ch0_act);
			d.svc_word  = q.mode[svc_ch][`EM_WORD];
			d.svc_memwr = q.mode[svc_ch][`EM_MEMWR];
			d.svc_xfer  = q.mode[svc_ch][`EM_XFER];
			d.svc_ioadr = q.mode[svc_ch][`EM_IOADR] ?
				q.ioadr[svc_ch] : 16'h0000;
		end
	end

	// ==========================================
	// state register
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			q <= '0;
			q.mask <= `MASK_RST;
			q.arb0 <= `ARB0_RST;
			q.arb4 <= `ARB4_RST;
			q.ch0_act <= (`ARB0_RST != `ARB_INACTIVE);
		end else begin
			q <= d;
		end
	end

	// ==========================================
	// answer fifo; a full fifo refuses reads via io_rd_ready
	answer_fifo #(
		.WIDTH (`FIFO_WIDTH),
		.DEPTH (`FIFO_DEPTH)
	) u_answer (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.in_valid  (push),
		.in_ready  (fifo_ready),
		.in_data   (push_data),
		.out_valid (rd_valid),
		.out_ready (rd_ready),
		.out_data  (rd_data)
	);

	// registered outputs; the arbiter answers with the level values
	assign io_rd_ready = fifo_ready;
	assign svc_grant   = q.svc_grant;
	assign svc_word    = q.svc_word;
	assign svc_memwr   = q.svc_memwr;
	assign svc_xfer    = q.svc_xfer;
	assign svc_ioadr   = q.svc_ioadr;
	assign arb_level0  = q.arb0;
	assign arb_level4  = q.arb4;
	assign ch0_active  = q.ch0_act;
	assign mask_out    = q.mask;
endmodule // dma_channel_programming_port

// ==== tb/dma_prog_assertions.sv ====
// concurrent checks on the pins of the dma programming port
`timescale 1ns/1ps
`include "dma_prog_map.svh"

module dma_prog_assertions (
	input wire logic        clk_sys,     // clock
	input wire logic        rst_b,       // reset, low
	input wire logic [15:0] io_addr,     // port address
	input wire logic        io_wr,       // write strobe
	input wire logic        io_rd,       // read strobe
	input wire logic [7:0]  io_wdata,    // write byte
	input wire logic        io_rd_ready, // read taken
	input wire logic        rd_valid,    // answer present
	input wire logic        rd_ready,    // answer popped
	input wire logic [7:0]  rd_data,     // answer byte
	input wire logic        svc_req,     // service ask
	input wire logic [2:0]  svc_ch,      // asking channel
	input wire logic        svc_grant,   // service given
	input wire logic [3:0]  arb_level0,  // level ch0
	input wire logic [3:0]  arb_level4,  // level ch4
	input wire logic        ch0_active,  // ch0 usable
	input wire logic [7:0]  mask_out     // masks
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	// ==========================================
	// function port writes, where direct commands act
	logic fn_wr;
	assign fn_wr = io_wr && io_addr == `PORT_FUNC;

	AST_MASK_SET: assert property (fn_wr && io_wdata[7:4] == 4'h9 |=> mask_out[$past(io_wdata[2:0])])
		else $error("mask bit not set by direct command");
	AST_MASK_CLR: assert property (fn_wr && io_wdata[7:4] == 4'hA |=> !mask_out[$past(io_wdata[2:0])])
		else $error("mask bit not cleared by direct command");
	AST_MASTER: assert property (fn_wr && io_wdata[7:4] == 4'hD |=> mask_out == `MASK_RST)
		else $error("master clear left masks open");
	AST_MASK_HOLD: assert property (!fn_wr |=> $stable(mask_out))
		else $error("masks moved without a function write");
	AST_GRANT_MASKED: assert property (svc_req && mask_out[svc_ch] |=> !svc_grant)
		else $error("masked channel was granted");
	AST_GRANT_OK: assert property (svc_req && !mask_out[svc_ch] && (svc_ch != 3'd0 || ch0_active) |=> svc_grant)
		else $error("open channel not granted");
	AST_CH0_LEVEL: assert property ($stable(arb_level0) |-> ch0_active == (arb_level0 != `ARB_INACTIVE))
		else $error("channel 0 activity disagrees with level");
	AST_ARB_HOLD: assert property (!io_wr |=> $stable(arb_level0) && $stable(arb_level4))
		else $error("level moved without a write");
	AST_READ_PUSH: assert property (io_rd && io_rd_ready && !rd_valid |=> rd_valid)
		else $error("taken read gave no answer byte");
	AST_ANSWER_STANDS: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
		else $error("answer byte dropped before pop");

	// main scenarios reached
	COV_GRANT: cover property (svc_grant);
	COV_FULL: cover property (!io_rd_ready);
	COV_STALL: cover property (rd_valid && !rd_ready);
endmodule // dma_prog_assertions

bind dma_channel_programming_port dma_prog_assertions dma_prog_assertions_inst (
	.clk_sys, .rst_b, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rd_ready, .rd_valid,
	.rd_ready, .rd_data, .svc_req, .svc_ch, .svc_grant, .arb_level0, .arb_level4,
	.ch0_active, .mask_out
);

// ==== tb/host_reader.sv ====
// processor side model that pops answer bytes from the port
`timescale 1ns/1ps

module host_reader (
	input  wire logic       clk_sys,  // clock
	input  wire logic       rst_b,    // reset, low
	input  wire logic       stall,    // hold pops off
	input  wire logic       slow,     // pop every other cycle
	input  wire logic       rd_valid, // answer present
	input  wire logic [7:0] rd_data,  // answer byte
	output logic            rd_ready  // pop strobe
);
	logic [7:0] got[$];
	logic       ph_q;

	// slow pacing makes answers stand across cycles
	assign rd_ready = !stall && (!slow || ph_q);

	// each popped byte queued in arrival order
	always @(posedge clk_sys) begin
		ph_q <= rst_b ? !ph_q : 1'b0;
		if (rst_b && rd_valid && rd_ready)
			got.push_back(rd_data);
	end
endmodule // host_reader

// ==== tb/testbench.sv ====
// self-checking bench of the dma programming port
`timescale 1ns/1ps
`include "dma_prog_map.svh"

module testbench;
	logic        clk_sys, rst_b, io_wr, io_rd, rd_ready, svc_req, stall, slow;
	logic        io_rd_ready, rd_valid, svc_grant, svc_word, svc_memwr, svc_xfer;
	logic        ch0_active;
	logic [15:0] io_addr, svc_ioadr;
	logic [7:0]  io_wdata, rd_data, term_event, arb_won, mask_out;
	logic [3:0]  arb_level0, arb_level4;
	logic [2:0]  svc_ch;
	logic [7:0]  cm_wr[5] = '{8'h0A, 8'h02, 8'h06, 8'h0E, 8'h09};
	logic [7:0]  cm_exp[5] = '{8'h45, 8'h41, 8'h4D, 8'h4D, 8'h4D};
	int          miscompares, check_count, n;

	dma_channel_programming_port dma_channel_programming_port_inst (
		.clk_sys, .rst_b, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rd_ready, .rd_valid,
		.rd_ready, .rd_data, .term_event, .arb_won, .svc_req, .svc_ch, .svc_grant,
		.svc_word, .svc_memwr, .svc_xfer, .svc_ioadr, .arb_level0, .arb_level4,
		.ch0_active, .mask_out
	);
	host_reader host_reader_inst (.clk_sys, .rst_b, .stall, .slow, .rd_valid, .rd_data, .rd_ready);

	// ==========================================
	// tasks
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic print_verdict();
		$display("checks=%0d miscompares=%0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// an idle edge after each write keeps back-to-back strobes apart
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		@(posedge clk_sys);
		#1 io_wr = 1'b0;
		@(posedge clk_sys) #1;
	endtask

	// read held until taken, then the popped byte compared
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		int m, k;
		m = host_reader_inst.got.size();
		io_addr = a;
		io_rd = 1'b1;
		for (k = 0; k < 50 && io_rd_ready !== 1'b1; k++)
			@(posedge clk_sys) #1;
		@(posedge clk_sys);
		#1 io_rd = 1'b0;
		for (k = 0; k < 50 && host_reader_inst.got.size() == m; k++)
			@(posedge clk_sys) #1;
		chk(host_reader_inst.got[m], e);
	endtask

	task automatic svc(input logic [2:0] c);
		svc_ch = c;
		svc_req = 1'b1;
		@(posedge clk_sys);
		#1 svc_req = 1'b0;
	endtask

	// ==========================================
	// clock and watchdog
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// ample margin over the roughly 160 cycles of tests
	initial begin
		#(5000 * 50);
		miscompares++;
		print_verdict();
	end

	// ==========================================
	// tests
	initial begin
		{rst_b, io_wr, io_rd, svc_req, stall, slow} = '0;
		{io_addr, io_wdata, term_event, arb_won, svc_ch} = '0;
		repeat (16) @(posedge clk_sys);
		#1 rst_b = 1'b1;
		@(posedge clk_sys) #1;
		chk(mask_out, `MASK_RST);
		chk(arb_level4, `ARB4_RST);
		chk(ch0_active, 1'b1);
		$display("test reset done");
		wr(`PORT_FUNC, 8'h02);
		wr(`PORT_EXEC, 8'h34);
		wr(`PORT_EXEC, 8'h12);
		wr(`PORT_FUNC, 8'h02);
		rd(`PORT_EXEC, 8'h34);
		rd(`PORT_EXEC, 8'h12);
		rd(`PORT_EXEC, 8'h00);
		wr(`PORT_FUNC, 8'h42);
		wr(`PORT_EXEC, 8'hA5);
		wr(`PORT_EXEC, 8'h5A);
		wr(`PORT_FUNC, 8'h52);
		rd(`PORT_EXEC, 8'hA5);
		rd(`PORT_EXEC, 8'h5A);
		$display("test pointer done");
		wr(`PORT_FUNC, 8'h72);
		wr(`PORT_EXEC, 8'h4D);
		for (int i = 0; i < 5; i++) begin
			wr(`PORT_MODE_LO, cm_wr[i]);
			wr(`PORT_FUNC, 8'h72);
			rd(`PORT_EXEC, cm_exp[i]);
		end
		wr(`PORT_FUNC, 8'hA2);
		svc(3'd2);
		chk(svc_grant, 1'b1);
		chk(svc_word, 1'b1);
		chk(svc_memwr, 1'b1);
		chk(svc_xfer, 1'b1);
		chk(svc_ioadr, 16'h1234);
		wr(`PORT_FUNC, 8'h92);
		svc(3'd3);
		chk(svc_grant, 1'b0);
		chk(svc_ioadr, 16'h0000);
		$display("test mode done");
		term_event = 8'h02;
		arb_won = 8'h84;
		@(posedge clk_sys) #1;
		{term_event, arb_won} = '0;
		rd(`PORT_STAT_LO, 8'h42);
		rd(`PORT_STAT_LO, 8'h00);
		wr(`PORT_FUNC, 8'h65);
		rd(`PORT_EXEC, 8'h80);
		rd(`PORT_STAT_HI, 8'h00);
		$display("test status done");
		wr(`PORT_FUNC, 8'h80);
		wr(`PORT_EXEC, 8'h04);
		wr(`PORT_FUNC, 8'hA0);
		chk(arb_level0, 4'h4);
		chk(ch0_active, 1'b0);
		svc(3'd0);
		chk(svc_grant, 1'b0);
		wr(`PORT_FUNC, 8'h80);
		rd(`PORT_EXEC, 8'h04);
		wr(`PORT_FUNC, 8'h80);
		wr(`PORT_EXEC, 8'h01);
		wr(`PORT_FUNC, 8'h81);
		rd(`PORT_EXEC, 8'h00);
		svc(3'd0);
		chk(svc_grant, 1'b1);
		wr(`PORT_FUNC, 8'hB0);
		rd(`PORT_EXEC, 8'h00);
		wr(`PORT_FUNC, 8'hD0);
		chk(mask_out, `MASK_RST);
		$display("test arbitration done");
		// mid-run reset must restore masks, the channel 0 level and clear pending flags
		wr(`PORT_FUNC, 8'hA2);
		term_event = 8'h10;
		@(posedge clk_sys) #1;
		term_event = 8'h00;
		rst_b = 1'b0;
		@(posedge clk_sys) #1;
		rst_b = 1'b1;
		@(posedge clk_sys) #1;
		chk(mask_out, `MASK_RST);
		chk(arb_level0, `ARB0_RST);
		chk(ch0_active, 1'b1);
		rd(`PORT_STAT_HI, 8'h00);
		$display("test reset again done");
		stall = 1'b1;
		n = host_reader_inst.got.size();
		io_addr = 16'h0100;
		io_rd = 1'b1;
		repeat (`FIFO_DEPTH + 1) @(posedge clk_sys);
		#1 io_rd = 1'b0;
		chk(io_rd_ready, 1'b0);
		slow = 1'b1;
		stall = 1'b0;
		repeat (24) @(posedge clk_sys);
		#1 chk(16'(host_reader_inst.got.size()), 16'(n + `FIFO_DEPTH));
		chk(rd_valid, 1'b0);
		$display("test fifo done");
		print_verdict();
	end
endmodule // testbench
